// *** verilog/crf_defs.vh ***
// Overview of operation
// RULE1: send a satellite count byte, then exactly that many satellite blocks.
// RULE2: each block starts its L1 data with signal strength in dB times four.
// RULE3: then L1 pseudorange double, L1 phase double, L1 Doppler float, in order.
// RULE4: phase falls and Doppler is negative while pseudorange rises.
// RULE5: the 13-byte L2 group is sent only when status A bit 0 is set.
// RULE6: L2 phase in L2 cycles and range difference valid only when status A bit 5 is one.
// RULE7: option bit 1 adds a 3-byte enhanced group per satellite, else omitted.
// RULE8: L1 slip counter is 8-bit, wraps, counts each L1 cycle slip.
// RULE9: L2 slip counter counts L2 slips and every civil/encrypted code change; a slip and a code change in the same cycle add only one.
// RULE10: after the last block send a two-byte checksum, then end byte 03h.
// RULE11: record type byte is 00h for survey data, 01h for position data.
// RULE12: page byte holds total pages in bits 0-3, current page in 4-7.
// RULE13: option bit 0 selects layout: zero expanded, one concise; the code copies ctrl bit 2 there but sends one layout.
// RULE14: option bits 2 to 7 are always zero.
// RULE15: status A bits 1 and 2 flag L1 and L2 slips since the last record.
// RULE16: status A bit 3 is L1 lock point, bit 4 says lock point valid.
// RULE17: status A bit 5 is always reported as zero.
// RULE18: status A bit 6 set when L1 data valid; L1 bytes always present.
// RULE19: status A bit 7 set when a new position was computed this cycle.
// RULE20: status B bit 0 gives L1 code, civil zero, precision one.
// RULE21: status B bit 1 gives L2 mode, civil or encrypted zero, precision one.
// RULE22: status B bit 2 flags L2 tracking on the encryption code.
// RULE23: status B bit 3 flags filtered L1 corrections; bits 4-7 are zero.
// RULE24: bytes go one at a time in field order, advancing only on accept.
`ifndef CRF_DEFS_VH
`define CRF_DEFS_VH
`define CRF_ADDR_CTRL    12'h000
`define CRF_ADDR_PAGE    12'h004
`define CRF_ADDR_COUNT   12'h008
`define CRF_ADDR_CKSUM   12'h00C
`define CRF_ADDR_STAT    12'h010
`define CRF_ADDR_MEM     12'h100
`define CRF_CTRL_START   0
`define CRF_CTRL_ENH     1
`define CRF_CTRL_CONCISE 2
`define CRF_CTRL_RECTYPE 3
`define CRF_CTRL_SFLIP   4
`define CRF_CTRL_RST     5'h0_0
`define CRF_PAGE_RST     8'h11
`define CRF_REC_SURVEY   8'h00
`define CRF_REC_POS      8'h01
`define CRF_ETX          8'h03
`define CRF_MAX_SATS     4'h8
`define CRF_L1_LAST      6'h1A
`define CRF_L2_LAST      6'h0C
`define CRF_ENH_LAST     6'h02
`define CRF_SA_L2        24
`define CRF_SA_LOCK      25
`define CRF_SA_LOCKV     26
`define CRF_SA_L1V       27
`define CRF_SA_NEWPOS    28
`endif

// *** verilog/crf_framer.v ***
`include "crf_defs.vh"
`default_nettype none
module crf_framer (
    input  wire        i_core_clk,   // core clock, 25 MHz
    input  wire        i_rst,        // async reset, active high
    input  wire        hsel,         // ahb slave select
    input  wire [11:0] haddr,        // ahb byte address
    input  wire [1:0]  htrans,       // ahb transfer type
    input  wire        hwrite,       // ahb write
    input  wire [2:0]  hsize,        // ahb size
    input  wire        hready,       // ahb bus ready
    input  wire [31:0] hwdata,       // ahb write data
    output wire [31:0] hrdata,       // ahb read data
    output wire        hreadyout,    // ahb slave ready
    output wire        hresp,        // ahb response
    input  wire [7:0]  i_l1_slip,    // per-satellite L1 slip pulse
    input  wire [7:0]  i_l2_slip,    // per-satellite L2 slip pulse
    input  wire [7:0]  i_l2_enc,     // per-satellite L2 on encrypted code
    output wire [7:0]  o_tx_data,    // packet byte
    output wire        o_tx_valid,   // packet byte valid
    input  wire        i_tx_ready,   // transmitter accepts byte
    output wire        o_busy        // framer sending
);

    localparam S_IDLE  = 4'd0;
    localparam S_REC   = 4'd1;
    localparam S_PAGE  = 4'd2;
    localparam S_OPT   = 4'd3;
    localparam S_CNT   = 4'd4;
    localparam S_L1    = 4'd5;
    localparam S_L2    = 4'd6;
    localparam S_ENH   = 4'd7;
    localparam S_CKHI  = 4'd8;
    localparam S_CKLO  = 4'd9;
    localparam S_ETX   = 4'd10;

    reg [31:0] sat_mem [0:127];
    reg [4:0]  ctrl_r;
    reg [7:0]  page_r;
    reg [3:0]  count_r;
    reg [15:0] cksum_r;
    reg [31:0] hrdata_r;
    reg        dp_wr_r;
    reg [11:0] dp_addr_r;
    reg [3:0]  state_r;
    reg [3:0]  state_nxt;
    reg [2:0]  sat_r;
    reg [5:0]  pos_r;
    reg [7:0]  tx_data_r;
    reg        tx_valid_r;
    reg [7:0]  byte_nxt;
    reg [7:0]  l1_cnt_r [0:7];
    reg [7:0]  l2_cnt_r [0:7];
    reg [7:0]  l1_stk_r;
    reg [7:0]  l2_stk_r;
    reg [7:0]  enc_q_r;

    wire       addr_ok  = hsel && htrans[1] && hready;
    wire       load     = (!tx_valid_r || i_tx_ready) && (state_r != S_IDLE);
    // a start written before the end byte has been taken is dropped, like the control writes
    wire       start    = dp_wr_r && (dp_addr_r == `CRF_ADDR_CTRL)
                          && hwdata[`CRF_CTRL_START] && !o_busy;
    wire [31:0] w1      = sat_mem[{sat_r, 4'd1}];
    wire [31:0] w10     = sat_mem[{sat_r, 4'd10}];
    wire       has_l2   = w1[`CRF_SA_L2];
    wire       last_sat = ({1'b0, sat_r} == (count_r - 4'd1));
    wire [7:0] sel_bit  = 8'h01 << sat_r;
    wire       sa_sent  = load && (state_r == S_L1) && (pos_r == 6'd1);

    // picks one byte of a word, lane 3 being the most significant
    function [7:0] lane_of;
        input [31:0] w;
        input [1:0]  lane;
        begin
            lane_of = w[{lane, 3'b000} +: 8];
        end
    endfunction

    // true for the satellite word area, 0x100 up to 0x2ff
    function in_sat_area;
        input [11:0] a;
        begin
            in_sat_area = (a[11:8] == 4'h1) || (a[11:8] == 4'h2);
        end
    endfunction

    // word index within the satellite area: slot times sixteen plus word
    function [6:0] mem_idx;
        input [11:0] a;
        begin
            mem_idx = {~a[8], a[7:2]};
        end
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign o_tx_data = tx_data_r;
    assign o_tx_valid = tx_valid_r;
    // busy covers the end byte until the transmitter has taken it
    assign o_busy    = (state_r != S_IDLE) || tx_valid_r;

    // ahb slave: address phase captured, writes land in the data phase
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 12'h000;
            hrdata_r  <= 32'h0000_0000;
        end else begin
            dp_wr_r <= addr_ok && hwrite;
            if (addr_ok) begin
                dp_addr_r <= haddr;
            end
            if (addr_ok && !hwrite) begin
                if (in_sat_area(haddr)) begin
                    hrdata_r <= sat_mem[mem_idx(haddr)];
                end else begin
                    case (haddr)
                        `CRF_ADDR_CTRL:  hrdata_r <= {27'd0, ctrl_r};
                        `CRF_ADDR_PAGE:  hrdata_r <= {24'd0, page_r};
                        `CRF_ADDR_COUNT: hrdata_r <= {28'd0, count_r};
                        `CRF_ADDR_CKSUM: hrdata_r <= {16'd0, cksum_r};
                        `CRF_ADDR_STAT:  hrdata_r <= {21'd0, sat_r, 3'd0, o_busy,
                                                      state_r};
                        default:         hrdata_r <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    always @(posedge i_core_clk) begin
        if (dp_wr_r && in_sat_area(dp_addr_r)) begin
            sat_mem[mem_idx(dp_addr_r)] <= hwdata;
        end
    end

    // control registers are frozen while a packet is going out
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r  <= `CRF_CTRL_RST;
            page_r  <= `CRF_PAGE_RST;
            count_r <= 4'h0;
            cksum_r <= 16'h0000;
        end else if (dp_wr_r && !o_busy) begin
            case (dp_addr_r)
                `CRF_ADDR_CTRL:  ctrl_r  <= {hwdata[4:1], 1'b0};
                `CRF_ADDR_PAGE:  page_r  <= hwdata[7:0];
                `CRF_ADDR_COUNT: count_r <= (hwdata[3:0] > `CRF_MAX_SATS) ?
                                            `CRF_MAX_SATS : hwdata[3:0];
                `CRF_ADDR_CKSUM: cksum_r <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // slip counters and sticky slip flags, one set per satellite slot
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_slip
            wire code_sw = i_l2_enc[g] ^ enc_q_r[g];
            wire clr     = sa_sent && (sat_r == g);
            always @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    l1_cnt_r[g] <= 8'h00;
                    l2_cnt_r[g] <= 8'h00;
                    l1_stk_r[g] <= 1'b0;
                    l2_stk_r[g] <= 1'b0;
                    enc_q_r[g]  <= 1'b0;
                end else begin
                    enc_q_r[g] <= i_l2_enc[g];
                    if (i_l1_slip[g]) begin
                        l1_cnt_r[g] <= l1_cnt_r[g] + 8'h01; // RULE8
                    end
                    if (i_l2_slip[g] || code_sw) begin
                        l2_cnt_r[g] <= l2_cnt_r[g] + 8'h01; // RULE9
                    end
                    // a slip landing on the clear edge is kept
                    if (i_l1_slip[g]) begin
                        l1_stk_r[g] <= 1'b1; // RULE15
                    end else if (clr) begin
                        l1_stk_r[g] <= 1'b0;
                    end
                    if (i_l2_slip[g]) begin
                        l2_stk_r[g] <= 1'b1; // RULE15
                    end else if (clr) begin
                        l2_stk_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    wire [7:0] stat_a = {w1[`CRF_SA_NEWPOS],                  // RULE19
                         w1[`CRF_SA_L1V],                     // RULE18
                         1'b0,                                // RULE17 RULE6
                         w1[`CRF_SA_LOCKV], w1[`CRF_SA_LOCK], // RULE16
                         (l2_stk_r & sel_bit) != 8'h00,       // RULE15
                         (l1_stk_r & sel_bit) != 8'h00,
                         has_l2};
    wire [7:0] stat_b = {4'h0,                                // RULE23
                         w10[3],
                         (i_l2_enc & sel_bit) != 8'h00,       // RULE22
                         w10[1],                              // RULE21
                         w10[0]};                             // RULE20

    // byte for the current position
    reg [5:0] k;
    reg [31:0] w;
    always @* begin
        byte_nxt = 8'h00;
        k = 6'd0;
        w = 32'h0000_0000;
        case (state_r)
            S_REC:  byte_nxt = ctrl_r[`CRF_CTRL_RECTYPE] ? `CRF_REC_POS
                                                         : `CRF_REC_SURVEY; // RULE11
            S_PAGE: byte_nxt = page_r; // RULE12
            S_OPT:  byte_nxt = {6'b00_0000,                       // RULE14
                                ctrl_r[`CRF_CTRL_ENH],
                                ctrl_r[`CRF_CTRL_CONCISE]};       // RULE13
            S_CNT:  byte_nxt = {4'h0, count_r}; // RULE1
            S_L1: begin
                w = sat_mem[{sat_r, 4'd0}];
                case (pos_r)
                    6'd0: byte_nxt = lane_of(w, 2'd0);
                    6'd1: byte_nxt = stat_a;
                    6'd2: byte_nxt = stat_b;
                    6'd3: byte_nxt = lane_of(w, 2'd1);
                    6'd4: byte_nxt = lane_of(w, 2'd3);
                    6'd5: byte_nxt = lane_of(w, 2'd2);
                    6'd6: byte_nxt = lane_of(w1, 2'd0); // RULE2
                    default: begin
                        // pseudorange, phase, doppler, msb first
                        k = pos_r - 6'd7;
                        w = sat_mem[{sat_r, k[5:2] + 4'd2}];
                        byte_nxt = lane_of(w, 2'd3 - k[1:0]); // RULE3
                        if ((pos_r == 6'd15) || (pos_r == 6'd23)) begin
                            byte_nxt[7] = byte_nxt[7] ^ ctrl_r[`CRF_CTRL_SFLIP]; // RULE4
                        end
                    end
                endcase
            end
            S_L2: begin
                if (pos_r == 6'd0) begin
                    byte_nxt = lane_of(w1, 2'd1);
                end else begin
                    k = pos_r - 6'd1;
                    w = sat_mem[{sat_r, k[5:2] + 4'd7}];
                    byte_nxt = lane_of(w, 2'd3 - k[1:0]);
                end
            end
            S_ENH: begin
                case (pos_r)
                    6'd0:    byte_nxt = lane_of(w1, 2'd2);
                    6'd1:    byte_nxt = l1_cnt_r[sat_r];
                    default: byte_nxt = l2_cnt_r[sat_r];
                endcase
            end
            S_CKHI: byte_nxt = cksum_r[15:8]; // RULE10
            S_CKLO: byte_nxt = cksum_r[7:0];
            S_ETX:  byte_nxt = `CRF_ETX;       // RULE10
            default: byte_nxt = 8'h00;
        endcase
    end

    // next state of the packet sequencer, from idle through the end byte
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: state_nxt = start ? S_REC : S_IDLE;
            S_REC:  state_nxt = S_PAGE;
            S_PAGE: state_nxt = S_OPT;
            S_OPT:  state_nxt = S_CNT;
            S_CNT:  state_nxt = (count_r == 4'h0) ? S_CKHI : S_L1; // RULE1
            S_L1: begin
                if (pos_r != `CRF_L1_LAST) begin
                    state_nxt = S_L1;
                end else if (has_l2) begin
                    state_nxt = S_L2; // RULE5
                end else if (ctrl_r[`CRF_CTRL_ENH]) begin
                    state_nxt = S_ENH; // RULE7
                end else begin
                    state_nxt = last_sat ? S_CKHI : S_L1;
                end
            end
            S_L2: begin
                if (pos_r != `CRF_L2_LAST) begin
                    state_nxt = S_L2;
                end else if (ctrl_r[`CRF_CTRL_ENH]) begin
                    state_nxt = S_ENH; // RULE7
                end else begin
                    state_nxt = last_sat ? S_CKHI : S_L1;
                end
            end
            S_ENH: begin
                if (pos_r != `CRF_ENH_LAST) begin
                    state_nxt = S_ENH;
                end else begin
                    state_nxt = last_sat ? S_CKHI : S_L1;
                end
            end
            S_CKHI: state_nxt = S_CKLO;
            S_CKLO: state_nxt = S_ETX;
            S_ETX:  state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r    <= S_IDLE;
            sat_r      <= 3'd0;
            pos_r      <= 6'd0;
            tx_data_r  <= 8'h00;
            tx_valid_r <= 1'b0;
        end else begin
            if (tx_valid_r && i_tx_ready && !load) begin
                tx_valid_r <= 1'b0;
            end
            if (state_r == S_IDLE) begin
                if (start) begin
                    state_r <= S_REC;
                    sat_r   <= 3'd0;
                    pos_r   <= 6'd0;
                end
            end else if (load) begin
                tx_data_r  <= byte_nxt;   // RULE24
                tx_valid_r <= 1'b1;
                state_r    <= state_nxt;
                if (state_nxt != state_r) begin
                    pos_r <= 6'd0;
                end else begin
                    pos_r <= (state_r == S_L1 && pos_r == `CRF_L1_LAST) ? 6'd0
                                                                         : pos_r + 6'd1;
                end
                if ((state_r == S_L1 || state_r == S_L2 || state_r == S_ENH)
                    && (state_nxt == S_L1) && (pos_r != 6'd0 || state_r != S_L1)
                    && !(state_r == S_L1 && pos_r != `CRF_L1_LAST)) begin
                    sat_r <= sat_r + 3'd1;
                end
            end
        end
    end

endmodule // crf_framer
`default_nettype wire

// *** tb/crf_host_model.sv ***
`default_nettype none
module crf_host_model (
    input  wire logic       i_clk,   // core clock
    input  wire logic       i_rst,   // async reset, active high
    input  wire logic [7:0] i_data,  // byte offered by the framer
    input  wire logic       i_valid, // byte offered
    input  wire logic       i_slow,  // stall three cycles in four
    output var  logic       o_ready  // byte accepted
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx_q [$];
    logic [1:0] tick_r;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_r  <= 2'h0;
            o_ready <= 1'b0;
        end else begin
            tick_r  <= tick_r + 2'h1;
            o_ready <= !i_slow || tick_r == 2'h3;
            if (i_valid && o_ready) rx_q.push_back(i_data);
        end
    end
endmodule // crf_host_model
`default_nettype wire

// *** tb/crf_framer_properties.sv ***
`default_nettype none
module crf_framer_props (
    input wire logic        i_core_clk, // core clock
    input wire logic        i_rst,      // async reset
    input wire logic        hsel,       // ahb select
    input wire logic [11:0] haddr,      // ahb address
    input wire logic [1:0]  htrans,     // ahb transfer type
    input wire logic        hwrite,     // ahb write
    input wire logic        hready,     // ahb ready
    input wire logic [31:0] hwdata,     // ahb write data
    input wire logic [7:0]  o_tx_data,  // packet byte
    input wire logic        o_tx_valid, // packet byte valid
    input wire logic        i_tx_ready, // byte accepted
    input wire logic        o_busy      // packet in progress
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] idx_r;
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) idx_r <= 9'h000;
        else if (!o_busy) idx_r <= 9'h000;
        else if (o_tx_valid && i_tx_ready) idx_r <= idx_r + 9'h001;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_start;
        hsel && htrans[1] && hwrite && hready && haddr == 12'h000 ##1 hwdata[0] && !o_busy;
    endsequence
    sequence s_rec_byte;
        o_tx_valid && o_tx_data[7:1] == 7'h00;
    endsequence
    a_start_rectype: assert property (s_start |-> ##[1:3] s_rec_byte)
        else $error("no record type byte after start");
    a_rectype_first: assert property (o_tx_valid && idx_r == 9'h000 |-> s_rec_byte)
        else $error("first byte is not a record type");
    a_opt_reserved: assert property (o_tx_valid && idx_r == 9'h002 |-> o_tx_data[7:2] == 6'h00)
        else $error("option byte reserved bits set");
    a_count_limit: assert property (o_tx_valid && idx_r == 9'h003 |-> o_tx_data <= 8'h08)
        else $error("satellite count above eight");
    a_hold_byte: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
        else $error("byte changed before accept");
    a_idle_quiet: assert property (!o_busy |-> !o_tx_valid)
        else $error("byte offered while idle");
    a_no_bubble: assert property (o_tx_valid && i_tx_ready |=> o_tx_valid || !o_busy)
        else $error("gap inside packet");
    a_etx_end: assert property ($fell(o_busy) |-> $past(o_tx_valid) && $past(i_tx_ready) && $past(o_tx_data) == 8'h03)
        else $error("packet ended without end byte");
endmodule // crf_framer_props
`default_nettype wire

// *** tb/crf_framer_bench.sv ***
`default_nettype none
module crf_framer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_core_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0]  i_l1_slip = 8'h00;
    logic [7:0]  i_l2_slip = 8'h00;
    logic [7:0]  i_l2_enc = 8'h00;
    logic        slow = 1'b0;
    wire  [31:0] hrdata;
    wire  [7:0]  o_tx_data;
    wire         hreadyout, hresp, o_tx_valid, i_tx_ready, o_busy;
    int          miscompares = 0;
    int          checks = 0;
    logic [31:0] m [8][11];
    logic [7:0]  l1c [8] = '{default: 8'h00};
    logic [7:0]  l2c [8] = '{default: 8'h00};
    logic [7:0]  sl1 = 8'h00;
    logic [7:0]  sl2 = 8'h00;
    logic [7:0]  exp_q [$];
    logic [31:0] q;
    always #20 i_core_clk = ~i_core_clk;
    crf_framer dut_u (.i_core_clk, .i_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .i_l1_slip,
        .i_l2_slip, .i_l2_enc, .o_tx_data, .o_tx_valid, .i_tx_ready, .o_busy);
    crf_host_model host_u (.i_clk(i_core_clk), .i_rst, .i_data(o_tx_data),
        .i_valid(o_tx_valid), .i_slow(slow), .o_ready(i_tx_ready));
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        hwrite <= wr;
        haddr  <= a;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask
    task automatic slips(input logic [7:0] l1, input logic [7:0] l2, input int n);
        repeat (n) begin
            i_l1_slip <= l1;
            i_l2_slip <= l2;
            @(posedge i_core_clk);
            i_l1_slip <= 8'h00;
            i_l2_slip <= 8'h00;
            @(posedge i_core_clk);
            for (int s = 0; s < 8; s++) begin
                l1c[s] += 8'(l1[s]);
                l2c[s] += 8'(l2[s]);
            end
            sl1 |= l1;
            sl2 |= l2;
        end
    endtask
    task automatic load(input logic [7:0] key);
        for (int s = 0; s < 8; s++) begin
            for (int w = 0; w < 11; w++) begin
                m[s][w] = {8'(key + 8'(s * 3)), 4'(s), 4'(w), 8'(s * 37 + w * 11), key};
                if (w == 1) m[s][w][31:29] = 3'h0;
                bus(1'b1, 12'h100 + 12'(s * 64 + w * 4), m[s][w]);
            end
        end
    endtask
    task automatic push32(input logic [31:0] v);
        for (int i = 3; i >= 0; i--) exp_q.push_back(v[i*8 +: 8]);
    endtask
    task automatic build(input logic [7:0] c, input int k, input logic [7:0] pg,
                         input logic [15:0] ck);
        logic [31:0] w1;
        logic [31:0] fl;
        fl = {c[4], 31'h0000_0000};
        exp_q = {};
        exp_q.push_back({7'h00, c[3]});
        exp_q.push_back(pg);
        exp_q.push_back({6'h00, c[1], c[2]});
        exp_q.push_back(8'(k));
        for (int s = 0; s < k; s++) begin
            w1 = m[s][1];
            exp_q.push_back(m[s][0][7:0]);
            exp_q.push_back({w1[28:27], 1'b0, w1[26:25], sl2[s], sl1[s], w1[24]});
            exp_q.push_back({4'h0, m[s][10][3], i_l2_enc[s], m[s][10][1:0]});
            exp_q.push_back(m[s][0][15:8]);
            exp_q.push_back(m[s][0][31:24]);
            exp_q.push_back(m[s][0][23:16]);
            exp_q.push_back(w1[7:0]);
            push32(m[s][2]);
            push32(m[s][3]);
            push32(m[s][4] ^ fl);
            push32(m[s][5]);
            push32(m[s][6] ^ fl);
            if (w1[24]) begin
                exp_q.push_back(w1[15:8]);
                push32(m[s][7]);
                push32(m[s][8]);
                push32(m[s][9]);
            end
            if (c[1]) begin
                exp_q.push_back(w1[23:16]);
                exp_q.push_back(l1c[s]);
                exp_q.push_back(l2c[s]);
            end
            sl1[s] = 1'b0;
            sl2[s] = 1'b0;
        end
        exp_q.push_back(ck[15:8]);
        exp_q.push_back(ck[7:0]);
        exp_q.push_back(8'h03);
    endtask
    // mid: register writes and a second start land while the packet runs
    task automatic run(input logic [7:0] c, input int n, input logic [7:0] pg,
                       input logic [15:0] ck, input logic mid);
        int t;
        bus(1'b1, 12'h004, {24'h00_0000, pg});
        bus(1'b1, 12'h008, 32'(n));
        bus(1'b1, 12'h00C, {16'h0000, ck});
        build(c, n > 8 ? 8 : n, pg, ck);
        host_u.rx_q = {};
        bus(1'b1, 12'h000, {24'h00_0000, c | 8'h01});
        if (mid) begin
            bus(1'b1, 12'h008, 32'h0000_0001);
            bus(1'b1, 12'h000, 32'h0000_0001);
        end
        t = 0;
        do begin
            @(posedge i_core_clk);
            t++;
        end while (o_busy !== 1'b0 && t < 4000);
        if (o_busy !== 1'b0) begin
            miscompares++;
            close_out();
        end
        repeat (4) @(posedge i_core_clk);
        chk("busy after packet", 32'h0, 32'(o_busy));
        chk("packet length", 32'(exp_q.size()), 32'(host_u.rx_q.size()));
        foreach (exp_q[i]) chk($sformatf("byte %0d", i), exp_q[i], host_u.rx_q[i]);
        bus(1'b0, 12'h008, 32'h0000_0000);
        chk("count register", 32'(n > 8 ? 8 : n), q);
        chk("bus response", 32'h0, 32'(hresp));
    endtask
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        bus(1'b0, 12'h004, 32'h0000_0000);
        chk("page reset", 32'h0000_0011, q);
        bus(1'b0, 12'hFFC, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0000, q);
        load(8'h5A);
        run(8'h04, 2, 8'h12, 16'hA55A, 1'b0);
        slow <= 1'b1;
        slips(8'h03, 8'h01, 3);
        slips(8'h02, 8'h00, 254);
        i_l2_enc <= 8'h01;
        l2c[0] += 8'h01;
        repeat (2) @(posedge i_core_clk);
        load(8'hC3);
        run(8'h1A, 3, 8'h23, 16'h0103, 1'b1);
        slow <= 1'b0;
        run(8'h06, 9, 8'h33, 16'hFFFE, 1'b0);
        bus(1'b0, 12'h010, 32'h0000_0000);
        chk("status register", 32'h0000_0700, q);
        close_out();
    end
endmodule // crf_framer_bench
bind crf_framer crf_framer_props chk_u (.i_core_clk, .i_rst, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hwdata, .o_tx_data, .o_tx_valid, .i_tx_ready, .o_busy);
`default_nettype wire
